// file: logic/pcs_pkg.sv
package pcs_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam int N_W = 4;
    localparam int K_W = 22;
    localparam int RATE_W = 18;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [6:0] OFS_FIRST_CTRL_1 = 7'h00;
    localparam logic [6:0] OFS_FIRST_CTRL_2 = 7'h01;
    localparam logic [6:0] OFS_FIRST_CTRL_3 = 7'h02;
    localparam logic [6:0] OFS_FIRST_CTRL_4 = 7'h03;
    localparam logic [6:0] OFS_SECOND_CTRL_1 = 7'h04;
    localparam logic [6:0] OFS_SECOND_CTRL_2 = 7'h05;
    localparam logic [6:0] OFS_SECOND_CTRL_3 = 7'h06;
    localparam logic [6:0] OFS_SECOND_CTRL_4 = 7'h07;
    localparam logic [6:0] OFS_POWER_CTRL = 7'h08;
    localparam logic [6:0] OFS_RX_STATUS = 7'h09;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int BIT_IN_DIV = 0;
    localparam int BIT_OUT_DOUBLE = 1;
    localparam int OUT_CODE_LO = 3;
    localparam int MASTER_SEL_LO = 5;
    localparam int AUX_SEL_LO = 7;
    localparam int N_LO = 5;
    localparam int K_MID_LO = 9;
    localparam int K_TOP_LO = 18;
    localparam int PD_FIRST = 0;
    localparam int PD_SECOND = 1;
    localparam int PD_RECEIVER = 2;
    localparam int PD_TRANSCEIVER = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [3:0] RST_INT_MULT = 4'h7;
    localparam logic [21:0] RST_FRAC_MULT = 22'h36FD21;
    localparam logic [1:0] RST_OUT_CODE = 2'h2;
    localparam logic [1:0] RST_AUX_SEL = 2'h3;
    localparam logic [1:0] RST_MASTER_SEL = 2'h0;
    localparam logic [3:0] RST_POWER = 4'hF;

    // ==========================================================
    // Pin source codes and divider figures
    // ==========================================================
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_FIRST = 2'h1;
    localparam logic [1:0] SEL_SECOND = 2'h2;
    localparam logic [1:0] SEL_OSC = 2'h3;
    localparam logic [4:0] DIV_CODE0 = 5'h02;
    localparam logic [4:0] DIV_CODE1 = 5'h04;
    localparam logic [4:0] DIV_CODE2 = 5'h08;
    localparam logic [4:0] DIV_CODE3 = 5'h0C;
    localparam logic [1:0] IN_DIV_ONE = 2'h1;
    localparam logic [1:0] IN_DIV_TWO = 2'h2;
    localparam logic [8:0] FS_MULT_FULL = 9'h100;
    localparam logic [8:0] FS_MULT_HALF = 9'h080;

    // ==========================================================
    // Sample rate class bounds in Hz, each with 1% margin
    // ==========================================================
    localparam logic [17:0] HIGH_LO = 18'h15516;
    localparam logic [17:0] HIGH_HI = 18'h17AC0;
    localparam logic [17:0] MID_LO = 18'h0AA8B;
    localparam logic [17:0] MID_HI = 18'h0BD60;
    localparam logic [17:0] LOW_LO = 18'h07BC0;
    localparam logic [17:0] LOW_HI = 18'h07E40;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        RATE_NONE,
        RATE_HIGH,
        RATE_MID,
        RATE_LOW
    } pcs_rate_class_t;

    typedef struct packed {
        logic in_div;
        logic out_double;
        logic [1:0] out_code;
        logic [3:0] int_mult;
        logic [21:0] frac_mult;
    } pcs_synth_reg_t;

    typedef struct packed {
        logic [3:0] int_mult;
        logic [21:0] frac_mult;
        logic [1:0] in_div_ratio;
        logic [4:0] out_div_ratio;
        logic out_div_used;
        logic [8:0] fs_mult;
    } pcs_synth_cfg_t;

endpackage

// file: logic/pcs_synth_cfg.sv
`timescale 1ns/100ps
module pcs_synth_cfg #(
    parameter bit IS_FIRST = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire pcs_pkg::pcs_synth_reg_t regs_in,
    input wire logic rx_mode_in,
    input wire logic [3:0] rx_int_mult_in,
    input wire logic [21:0] rx_frac_mult_in,
    output pcs_pkg::pcs_synth_cfg_t cfg_out
);
    import pcs_pkg::*;

    pcs_synth_cfg_t state;
    pcs_synth_cfg_t next_state;
    logic [4:0] base_div;

    // ==========================================================
    // Decode of one synthesizer's settings
    // ==========================================================
    // Base ratio from the divider code, doubled by the post-scale bit.
    always_comb begin
        unique case (regs_in.out_code)
            2'h0: base_div = DIV_CODE0;
            2'h1: base_div = DIV_CODE1;
            2'h2: base_div = DIV_CODE2;
            2'h3: base_div = DIV_CODE3;
        endcase
    end

    // The receiver owns the first synthesizer's multipliers in receive
    // mode; the output divider of either one is then not used.
    always_comb begin
        next_state = state;
        next_state.int_mult = regs_in.int_mult;
        next_state.frac_mult = regs_in.frac_mult;
        if (rx_mode_in && IS_FIRST) begin
            next_state.int_mult = rx_int_mult_in;
            next_state.frac_mult = rx_frac_mult_in;
        end
        next_state.in_div_ratio =
            regs_in.in_div ? IN_DIV_TWO : IN_DIV_ONE;
        next_state.out_div_ratio =
            regs_in.out_double ? base_div << 1 : base_div;
        next_state.out_div_used = !rx_mode_in;
        next_state.fs_mult = 9'h000;
        if (rx_mode_in) begin
            next_state.out_div_ratio = 5'h00;
            if (IS_FIRST) begin
                next_state.fs_mult =
                    regs_in.out_double ? FS_MULT_HALF : FS_MULT_FULL;
            end
        end
    end

    // Registered so every consumer sees a glitch-free setting.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_out = state;
endmodule

// file: logic/pcs_clock_ctrl.sv
`timescale 1ns/100ps
// How it works
// - Both synthesizers share one register layout and one decoder.
// - Aux pin source at bits 8:7: off, first, second, oscillator; resets to 11.
// - Master pin at bits 6:5: input, first, second, oscillator; resets 00.
// - In receive mode the receiver drives first synthesizer multipliers.
// - Incoming rate is sorted into three classes with 1% margins.
// - Receive mode ignores the second synthesizer's output divider bits.
// - Second synthesizer multipliers reset to 7 and 36FD21 hex.
// - Prescale bit clear passes oscillator clock, set halves it.
// - User mode output divide is 2, 4, 8, 12, doubled by post-scale.
// - In receive mode first post-scale picks 256 or 128 times fs.
module pcs_clock_ctrl (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic [6:0] REG_ADDR_IN,
    input wire logic [8:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [8:0] REG_RDATA_OUT,
    input wire logic OSC_CLK_IN,
    input wire logic FIRST_SYNTH_CLK_IN,
    input wire logic SECOND_SYNTH_CLK_IN,
    input wire logic [3:0] RX_INT_MULT_IN,
    input wire logic [21:0] RX_FRAC_MULT_IN,
    input wire logic [17:0] RX_RATE_HZ_IN,
    output logic AUX_CLOCK_PIN_OUT,
    output logic AUX_CLOCK_PIN_OE_OUT,
    output logic MASTER_CLOCK_PIN_OUT,
    output logic MASTER_CLOCK_PIN_OE_OUT,
    output logic [3:0] POWERDOWN_OUT,
    output logic RX_MODE_OUT,
    output pcs_pkg::pcs_rate_class_t RX_RATE_CLASS_OUT,
    output pcs_pkg::pcs_synth_cfg_t FIRST_SYNTH_CFG_OUT,
    output pcs_pkg::pcs_synth_cfg_t SECOND_SYNTH_CFG_OUT
);
    import pcs_pkg::*;

    typedef struct packed {
        pcs_synth_reg_t [1:0] synth;
        logic [1:0] aux_sel;
        logic [1:0] master_sel;
        logic [3:0] power;
        logic [8:0] rdata;
        logic aux_out;
        logic aux_oe;
        logic master_out;
        logic master_oe;
        logic rx_mode;
        pcs_rate_class_t rate_class;
    } pcs_top_state_t;

    pcs_top_state_t state;
    pcs_top_state_t next_state;
    pcs_synth_cfg_t [1:0] cfg;
    pcs_synth_reg_t rd_synth;
    logic [8:0] rd_word;
    logic aux_src;
    logic master_src;

    // ==========================================================
    // Per-synthesizer decode
    // ==========================================================
    // One decoder type serves both; only the first listens to the
    // receiver's multipliers.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_synth
            pcs_synth_cfg #(
                .IS_FIRST(i == 0)
            ) u_cfg (
                .clk_in(SYS_CLK_IN),
                .rst_in(RST_IN),
                .regs_in(state.synth[i]),
                .rx_mode_in(state.rx_mode),
                .rx_int_mult_in(RX_INT_MULT_IN),
                .rx_frac_mult_in(RX_FRAC_MULT_IN),
                .cfg_out(cfg[i])
            );
        end
    endgenerate

    // ==========================================================
    // Register read mux
    // ==========================================================
    // Offsets 0-3 address the first synthesizer and 4-7 the second; the
    // pin source fields exist only in the second's fourth register.
    always_comb begin
        rd_word = 9'h000;
        rd_synth = state.synth[REG_ADDR_IN[2]];
        if (REG_ADDR_IN <= OFS_SECOND_CTRL_4) begin
            unique case (REG_ADDR_IN[1:0])
                2'h0: rd_word = rd_synth.frac_mult[8:0];
                2'h1: rd_word = rd_synth.frac_mult[17:K_MID_LO];
                2'h2: begin
                    rd_word[3:0] = rd_synth.frac_mult[21:K_TOP_LO];
                    rd_word[8:N_LO] = rd_synth.int_mult;
                end
                2'h3: begin
                    rd_word[BIT_IN_DIV] = rd_synth.in_div;
                    rd_word[BIT_OUT_DOUBLE] = rd_synth.out_double;
                    rd_word[4:OUT_CODE_LO] = rd_synth.out_code;
                    if (REG_ADDR_IN[2]) begin
                        rd_word[6:MASTER_SEL_LO] = state.master_sel;
                        rd_word[8:AUX_SEL_LO] = state.aux_sel;
                    end
                end
            endcase
        end else if (REG_ADDR_IN == OFS_POWER_CTRL) begin
            rd_word[3:0] = state.power;
        end else if (REG_ADDR_IN == OFS_RX_STATUS) begin
            rd_word[1:0] = state.rate_class;
            rd_word[2] = state.rx_mode;
        end
    end

    // ==========================================================
    // Pin source selection
    // ==========================================================
    // Clocks are sampled as levels, so the pins carry a one-cycle
    // delayed copy; a real chip would mux the analogue clocks directly.
    always_comb begin
        unique case (state.aux_sel)
            SEL_NONE: aux_src = 1'b0;
            SEL_FIRST: aux_src = FIRST_SYNTH_CLK_IN;
            SEL_SECOND: aux_src = SECOND_SYNTH_CLK_IN;
            SEL_OSC: aux_src = OSC_CLK_IN;
        endcase
        unique case (state.master_sel)
            SEL_NONE: master_src = 1'b0;
            SEL_FIRST: master_src = FIRST_SYNTH_CLK_IN;
            SEL_SECOND: master_src = SECOND_SYNTH_CLK_IN;
            SEL_OSC: master_src = OSC_CLK_IN;
        endcase
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_state = state;
        if (REG_WR_IN) begin
            for (int i = 0; i < 2; i++) begin
                if (REG_ADDR_IN[6:2] == 5'(i)) begin
                    unique case (REG_ADDR_IN[1:0])
                        2'h0: next_state.synth[i].frac_mult[8:0] =
                            REG_WDATA_IN;
                        2'h1: next_state.synth[i].frac_mult[17:K_MID_LO] =
                            REG_WDATA_IN;
                        2'h2: begin
                            next_state.synth[i].frac_mult[21:K_TOP_LO] =
                                REG_WDATA_IN[3:0];
                            next_state.synth[i].int_mult =
                                REG_WDATA_IN[8:N_LO];
                        end
                        2'h3: begin
                            next_state.synth[i].in_div =
                                REG_WDATA_IN[BIT_IN_DIV];
                            next_state.synth[i].out_double =
                                REG_WDATA_IN[BIT_OUT_DOUBLE];
                            next_state.synth[i].out_code =
                                REG_WDATA_IN[4:OUT_CODE_LO];
                        end
                    endcase
                end
            end
            if (REG_ADDR_IN == OFS_SECOND_CTRL_4) begin
                next_state.master_sel = REG_WDATA_IN[6:MASTER_SEL_LO];
                next_state.aux_sel = REG_WDATA_IN[8:AUX_SEL_LO];
            end
            if (REG_ADDR_IN == OFS_POWER_CTRL) begin
                next_state.power = REG_WDATA_IN[3:0];
            end
        end
        if (REG_RD_IN) begin
            next_state.rdata = rd_word;
        end
        // Receive mode follows the receiver and transceiver power bits.
        next_state.rx_mode = !state.power[PD_RECEIVER] &&
                             !state.power[PD_TRANSCEIVER];
        // Pins: aux tristated on 00, master is an input on 00.
        next_state.aux_oe = (state.aux_sel != SEL_NONE);
        next_state.aux_out = aux_src;
        next_state.master_oe = (state.master_sel != SEL_NONE);
        next_state.master_out = master_src;
        // Rate classes; outside all windows no class is claimed.
        next_state.rate_class = RATE_NONE;
        if (RX_RATE_HZ_IN >= HIGH_LO && RX_RATE_HZ_IN <= HIGH_HI) begin
            next_state.rate_class = RATE_HIGH;
        end else if (RX_RATE_HZ_IN >= MID_LO && RX_RATE_HZ_IN <= MID_HI) begin
            next_state.rate_class = RATE_MID;
        end else if (RX_RATE_HZ_IN >= LOW_LO && RX_RATE_HZ_IN <= LOW_HI) begin
            next_state.rate_class = RATE_LOW;
        end
        if (!state.rx_mode) begin
            next_state.rate_class = RATE_NONE;
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Defaults let a 12 MHz oscillator receive without reprogramming.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state <= '0;
            for (int i = 0; i < 2; i++) begin
                state.synth[i].int_mult <= RST_INT_MULT;
                state.synth[i].frac_mult <= RST_FRAC_MULT;
                state.synth[i].out_code <= RST_OUT_CODE;
            end
            state.aux_sel <= RST_AUX_SEL;
            state.master_sel <= RST_MASTER_SEL;
            state.power <= RST_POWER;
        end else begin
            state <= next_state;
        end
    end

    assign REG_RDATA_OUT = state.rdata;
    assign AUX_CLOCK_PIN_OUT = state.aux_out;
    assign AUX_CLOCK_PIN_OE_OUT = state.aux_oe;
    assign MASTER_CLOCK_PIN_OUT = state.master_out;
    assign MASTER_CLOCK_PIN_OE_OUT = state.master_oe;
    assign POWERDOWN_OUT = state.power;
    assign RX_MODE_OUT = state.rx_mode;
    assign RX_RATE_CLASS_OUT = state.rate_class;
    assign FIRST_SYNTH_CFG_OUT = cfg[0];
    assign SECOND_SYNTH_CFG_OUT = cfg[1];
endmodule

// file: verification/pcs_clk_src.sv
`timescale 1ns/100ps
// ==========================================================
// Clock sources on the far side
// ==========================================================
module pcs_clk_src (
    input wire logic clk_in,
    output logic osc_out,
    output logic first_out,
    output logic second_out
);
    logic [2:0] cnt = 3'h0;
    // Three slow clocks at different rates, so a wrong source shows.
    always @(posedge clk_in) begin
        cnt <= cnt + 3'h1;
    end
    assign osc_out = cnt[0];
    assign first_out = cnt[1];
    assign second_out = cnt[2];
endmodule

// file: verification/pcs_clock_ctrl_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// Checker for pin selection, dividers and receive mode
// ==========================================================
module pcs_clock_ctrl_chk (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic [6:0] REG_ADDR_IN,
    input wire logic [8:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic OSC_CLK_IN,
    input wire logic FIRST_SYNTH_CLK_IN,
    input wire logic SECOND_SYNTH_CLK_IN,
    input wire logic [3:0] RX_INT_MULT_IN,
    input wire logic [21:0] RX_FRAC_MULT_IN,
    input wire logic [17:0] RX_RATE_HZ_IN,
    input wire logic AUX_CLOCK_PIN_OUT,
    input wire logic AUX_CLOCK_PIN_OE_OUT,
    input wire logic MASTER_CLOCK_PIN_OUT,
    input wire logic MASTER_CLOCK_PIN_OE_OUT,
    input wire logic RX_MODE_OUT,
    input wire pcs_pkg::pcs_rate_class_t RX_RATE_CLASS_OUT,
    input wire pcs_pkg::pcs_synth_cfg_t FIRST_SYNTH_CFG_OUT,
    input wire pcs_pkg::pcs_synth_cfg_t SECOND_SYNTH_CFG_OUT
);
    import pcs_pkg::*;
    logic [4:0] r3;
    logic [8:0] r7;
    logic [3:0] srcs;
    pcs_synth_cfg_t c1;
    pcs_synth_cfg_t c2;
    // Index order follows the select codes: none, first, second, osc.
    assign srcs = {OSC_CLK_IN, SECOND_SYNTH_CLK_IN, FIRST_SYNTH_CLK_IN, 1'b0};
    assign c1 = FIRST_SYNTH_CFG_OUT;
    assign c2 = SECOND_SYNTH_CFG_OUT;
    // Shadow of the divider and pin fields, kept from the write strobes.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            r3 <= 5'h10;
            r7 <= 9'h190;
        end else if (REG_WR_IN && REG_ADDR_IN == 7'h03) begin
            r3 <= REG_WDATA_IN[4:0];
        end else if (REG_WR_IN && REG_ADDR_IN == 7'h07) begin
            r7 <= REG_WDATA_IN;
        end
    end
    // Output divide ratio for a {code, doubling} pair.
    function automatic logic [4:0] div(input logic [2:0] c);
        logic [4:0] b;
        b = (c[2:1] == 2'h3) ? 5'h0C : 5'h02 << c[2:1];
        return c[0] ? b << 1 : b;
    endfunction
    // Class windows are inclusive at both ends.
    function automatic pcs_rate_class_t cls(input logic [17:0] r);
        return (r >= 18'h15516 && r <= 18'h17AC0) ? RATE_HIGH :
            (r >= 18'h0AA8B && r <= 18'h0BD60) ? RATE_MID :
            (r >= 18'h07BC0 && r <= 18'h07E40) ? RATE_LOW : RATE_NONE;
    endfunction
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    property p_aux;
        !$past(RST_IN) |-> AUX_CLOCK_PIN_OE_OUT == ($past(r7[8:7]) != 2'h0)
            && (!AUX_CLOCK_PIN_OE_OUT
            || AUX_CLOCK_PIN_OUT == $past(srcs[r7[8:7]]));
    endproperty
    a_aux: assert property (p_aux)
        else $error("aux pin enable or source wrong");
    property p_master;
        !$past(RST_IN) |-> MASTER_CLOCK_PIN_OE_OUT == ($past(r7[6:5]) != 2'h0)
            && (!MASTER_CLOCK_PIN_OE_OUT
            || MASTER_CLOCK_PIN_OUT == $past(srcs[r7[6:5]]));
    endproperty
    a_master: assert property (p_master)
        else $error("master pin direction or source wrong");
    // Mode is required stable so either gating point of the class agrees.
    property p_rate;
        !$past(RST_IN) && $stable(RX_MODE_OUT) |-> RX_RATE_CLASS_OUT ==
            (RX_MODE_OUT ? cls($past(RX_RATE_HZ_IN)) : RATE_NONE);
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate class wrong");
    property p_rx_first;
        RX_MODE_OUT [*3] |-> c1.int_mult == $past(RX_INT_MULT_IN)
            && c1.frac_mult == $past(RX_FRAC_MULT_IN)
            && c1.fs_mult == ($past(r3[1]) ? 9'h080 : 9'h100);
    endproperty
    a_rx_first: assert property (p_rx_first)
        else $error("first synthesizer not steered by receiver");
    property p_rx_second;
        RX_MODE_OUT [*3] |-> c2.out_div_ratio == 5'h00 && !c2.out_div_used;
    endproperty
    a_rx_second: assert property (p_rx_second)
        else $error("second divider used in receive mode");
    property p_user;
        (!RX_MODE_OUT) [*3] |-> c2.out_div_used
            && c2.out_div_ratio == $past(div({r7[4:3], r7[1]}))
            && c1.out_div_ratio == $past(div({r3[4:3], r3[1]}));
    endproperty
    a_user: assert property (p_user)
        else $error("user mode divide ratio wrong");
    property p_pre;
        !$past(RST_IN) |-> c1.in_div_ratio == ($past(r3[0]) ? 2'h2 : 2'h1)
            && c2.in_div_ratio == ($past(r7[0]) ? 2'h2 : 2'h1);
    endproperty
    a_pre: assert property (p_pre)
        else $error("prescale ratio wrong");
    property p_rst;
        $fell(RST_IN) |=> c2.int_mult == 4'h7 && c2.frac_mult == 22'h36FD21;
    endproperty
    a_rst: assert property (p_rst)
        else $error("second multipliers not at reset values");
    c_rx: cover property (RX_MODE_OUT [*3]);
    c_high: cover property (RX_RATE_CLASS_OUT == RATE_HIGH);
    c_tri: cover property (!AUX_CLOCK_PIN_OE_OUT);
endmodule
bind pcs_clock_ctrl pcs_clock_ctrl_chk u_chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .OSC_CLK_IN(OSC_CLK_IN), .FIRST_SYNTH_CLK_IN(FIRST_SYNTH_CLK_IN),
    .SECOND_SYNTH_CLK_IN(SECOND_SYNTH_CLK_IN),
    .RX_INT_MULT_IN(RX_INT_MULT_IN), .RX_FRAC_MULT_IN(RX_FRAC_MULT_IN),
    .RX_RATE_HZ_IN(RX_RATE_HZ_IN), .AUX_CLOCK_PIN_OUT(AUX_CLOCK_PIN_OUT),
    .AUX_CLOCK_PIN_OE_OUT(AUX_CLOCK_PIN_OE_OUT),
    .MASTER_CLOCK_PIN_OUT(MASTER_CLOCK_PIN_OUT),
    .MASTER_CLOCK_PIN_OE_OUT(MASTER_CLOCK_PIN_OE_OUT),
    .RX_MODE_OUT(RX_MODE_OUT), .RX_RATE_CLASS_OUT(RX_RATE_CLASS_OUT),
    .FIRST_SYNTH_CFG_OUT(FIRST_SYNTH_CFG_OUT),
    .SECOND_SYNTH_CFG_OUT(SECOND_SYNTH_CFG_OUT)
);

// file: verification/pcs_clock_ctrl_test.sv
`timescale 1ns/100ps
// ==========================================================
// Register level test of the clock control block
// ==========================================================
module pcs_clock_ctrl_test;
    import pcs_pkg::*;
    logic SYS_CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    logic [6:0] REG_ADDR_IN = 7'h00;
    logic [8:0] REG_WDATA_IN = 9'h000;
    logic REG_WR_IN = 1'b0;
    logic REG_RD_IN = 1'b0;
    logic [3:0] RX_INT_MULT_IN = 4'h9;
    logic [21:0] RX_FRAC_MULT_IN = 22'h2A5A5A;
    logic [17:0] RX_RATE_HZ_IN = 18'h0AC44;
    logic [8:0] REG_RDATA_OUT;
    logic OSC_CLK_IN, FIRST_SYNTH_CLK_IN, SECOND_SYNTH_CLK_IN;
    logic AUX_CLOCK_PIN_OUT, AUX_CLOCK_PIN_OE_OUT;
    logic MASTER_CLOCK_PIN_OUT, MASTER_CLOCK_PIN_OE_OUT;
    logic [3:0] POWERDOWN_OUT;
    logic RX_MODE_OUT;
    pcs_rate_class_t RX_RATE_CLASS_OUT;
    pcs_synth_cfg_t FIRST_SYNTH_CFG_OUT, SECOND_SYNTH_CFG_OUT, cfg;
    logic [4:0] dv [4] = '{5'h02, 5'h04, 5'h08, 5'h0C};
    logic [17:0] rates [7] = '{18'h15516, 18'h15515, 18'h17AC0,
        18'h0BD60, 18'h0BD61, 18'h07E41, 18'h07BC0};
    pcs_rate_class_t cls [7] = '{RATE_HIGH, RATE_NONE, RATE_HIGH,
        RATE_MID, RATE_NONE, RATE_NONE, RATE_LOW};
    int error_cnt = 0;
    int checks = 0;
    always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
    pcs_clk_src src (.clk_in(SYS_CLK_IN), .osc_out(OSC_CLK_IN),
        .first_out(FIRST_SYNTH_CLK_IN), .second_out(SECOND_SYNTH_CLK_IN));
    pcs_clock_ctrl dut (
        .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN),
        .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
        .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
        .OSC_CLK_IN(OSC_CLK_IN), .FIRST_SYNTH_CLK_IN(FIRST_SYNTH_CLK_IN),
        .SECOND_SYNTH_CLK_IN(SECOND_SYNTH_CLK_IN),
        .RX_INT_MULT_IN(RX_INT_MULT_IN), .RX_FRAC_MULT_IN(RX_FRAC_MULT_IN),
        .RX_RATE_HZ_IN(RX_RATE_HZ_IN), .AUX_CLOCK_PIN_OUT(AUX_CLOCK_PIN_OUT),
        .AUX_CLOCK_PIN_OE_OUT(AUX_CLOCK_PIN_OE_OUT),
        .MASTER_CLOCK_PIN_OUT(MASTER_CLOCK_PIN_OUT),
        .MASTER_CLOCK_PIN_OE_OUT(MASTER_CLOCK_PIN_OE_OUT),
        .POWERDOWN_OUT(POWERDOWN_OUT), .RX_MODE_OUT(RX_MODE_OUT),
        .RX_RATE_CLASS_OUT(RX_RATE_CLASS_OUT),
        .FIRST_SYNTH_CFG_OUT(FIRST_SYNTH_CFG_OUT),
        .SECOND_SYNTH_CFG_OUT(SECOND_SYNTH_CFG_OUT));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK_IN);
        #1;
    endtask
    // The strobe stands for exactly one sampling edge.
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge SYS_CLK_IN);
        REG_ADDR_IN <= a;
        REG_WDATA_IN <= d;
        REG_WR_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        REG_WR_IN <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        @(posedge SYS_CLK_IN);
        REG_ADDR_IN <= a;
        REG_RD_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        REG_RD_IN <= 1'b0;
        #1;
        check(REG_RDATA_OUT, exp);
    endtask
    task automatic finish_test;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A hang is cut after well over the expected run length.
    initial begin
        repeat (20000) @(posedge SYS_CLK_IN);
        error_cnt++;
        finish_test;
    end
    // Main sequence: reset, pins, dividers, multipliers, receive mode.
    initial begin
        repeat (3) @(posedge SYS_CLK_IN);
        RST_IN <= 1'b0;
        tick(3);
        for (int b = 0; b < 8; b += 4) begin
            rd(7'(b), 9'h121);
            rd(7'(b + 1), 9'h17E);
            rd(7'(b + 2), 9'h0ED);
        end
        rd(7'h03, 9'h010);
        rd(7'h07, 9'h190);
        check(SECOND_SYNTH_CFG_OUT.frac_mult, 22'h36FD21);
        wr(7'h08, 9'h00F);
        for (int i = 0; i < 4; i++) begin
            wr(7'h07, {i[1:0], i[1:0], 5'h10});
            tick(3);
            check(AUX_CLOCK_PIN_OE_OUT, i != 0);
            check(MASTER_CLOCK_PIN_OE_OUT, i != 0);
            rd(7'h07, {i[1:0], i[1:0], 5'h10});
        end
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 8; m++) begin
                wr(s ? 7'h07 : 7'h03, {4'hF, m[2:1], 1'b0, m[0], m[0]});
                tick(3);
                cfg = s ? SECOND_SYNTH_CFG_OUT : FIRST_SYNTH_CFG_OUT;
                check(cfg.out_div_ratio, dv[m[2:1]] << m[0]);
                check(cfg.in_div_ratio, m[0] ? 2'h2 : 2'h1);
            end
        end
        rd(7'h03, 9'h01B);
        wr(7'h04, 9'h1BA);
        wr(7'h05, 9'h024);
        wr(7'h06, 9'h103);
        wr(7'h00, 9'h1FF);
        wr(7'h01, 9'h1FF);
        wr(7'h02, 9'h1BF);
        tick(3);
        check(SECOND_SYNTH_CFG_OUT.int_mult, 4'h8);
        check(SECOND_SYNTH_CFG_OUT.frac_mult, 22'h0C49BA);
        check(FIRST_SYNTH_CFG_OUT.frac_mult, 22'h3FFFFF);
        rd(7'h02, 9'h1AF);
        // Receiver start: power down, program, enable receiver, then loops.
        wr(7'h08, 9'h00F);
        wr(7'h03, 9'h012);
        wr(7'h07, 9'h190);
        wr(7'h04, 9'h121);
        wr(7'h05, 9'h17E);
        wr(7'h06, 9'h0ED);
        wr(7'h08, 9'h003);
        wr(7'h08, 9'h000);
        tick(3);
        check(POWERDOWN_OUT, 4'h0);
        check(FIRST_SYNTH_CFG_OUT.int_mult, 4'h9);
        check(FIRST_SYNTH_CFG_OUT.frac_mult, 22'h2A5A5A);
        check(FIRST_SYNTH_CFG_OUT.fs_mult, 9'h080);
        check(SECOND_SYNTH_CFG_OUT.out_div_used, 1'b0);
        for (int i = 0; i < 7; i++) begin
            @(posedge SYS_CLK_IN);
            RX_RATE_HZ_IN <= rates[i];
            RX_INT_MULT_IN <= 4'(i + 5);
            tick(3);
            check(RX_RATE_CLASS_OUT, cls[i]);
        end
        wr(7'h09, 9'h003);
        rd(7'h09, 9'h007);
        wr(7'h08, 9'h00F);
        wr(7'h40, 9'h1FF);
        rd(7'h40, 9'h000);
        tick(4);
        check(RX_RATE_CLASS_OUT, RATE_NONE);
        check(SECOND_SYNTH_CFG_OUT.out_div_ratio, 5'h08);
        wr(7'h07, 9'h0A0);
        // A second reset in mid-run must restore the pin selection.
        @(posedge SYS_CLK_IN);
        RST_IN <= 1'b1;
        repeat (2) @(posedge SYS_CLK_IN);
        RST_IN <= 1'b0;
        tick(3);
        rd(7'h07, 9'h190);
        finish_test;
    end
endmodule
